/* File: sim/hf_osc_control_props.sv */
// Checker for the oscillator control ports
`default_nettype none
module hf_osc_control_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire hf_osc_pkg::reg_req_s req,
   input wire hf_osc_pkg::wake_s wake_in,
   input wire logic clock_recovery_en,
   input wire logic [4:0] recovery_trim,
   input wire logic osc_run,
   input wire logic [4:0] osc_trim,
   input wire logic core_clock_tick,
   input wire hf_osc_pkg::sys_src_e sys_clock_source,
   input wire hf_osc_pkg::usb_src_e usb_clock_source,
   input wire logic suspended
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Wake requests seen while suspended
   sequence s_usb_wake;
      suspended && wake_in.usb_event;
   endsequence
   sequence s_pwr_wake;
      suspended && (wake_in.bus_power_level == wake_in.bus_power_polarity_select);
   endsequence
   a_src_fixed: assert property (sys_clock_source == hf_osc_pkg::SRC_HF_OSC)
      else $error("core clock source moved");
   a_usb_src: assert property (usb_clock_source == hf_osc_pkg::USB_SRC_HF_OSC)
      else $error("usb clock source moved");
   a_susp_stops: assert property (suspended |-> !osc_run)
      else $error("oscillator runs in suspend");
   a_usb_wake: assert property (s_usb_wake |-> ##[1:3] osc_run)
      else $error("no restart on usb event");
   a_pwr_wake: assert property (s_pwr_wake |-> ##[1:3] osc_run)
      else $error("no restart on bus power match");
   a_tick_gate: assert property (!osc_run |-> !core_clock_tick)
      else $error("tick while oscillator stopped");
   a_trim_recov: assert property (clock_recovery_en |=> osc_trim == $past(recovery_trim))
      else $error("trim not following recovery");
   a_trim_write: assert property (req.wr && req.addr == hf_osc_pkg::ADDR_TRIM && !clock_recovery_en
      |=> {3'h0, osc_trim} == ($past(req.wdata) & 8'h1f)) else $error("trim write lost");
endmodule // hf_osc_control_props
bind hf_osc_control hf_osc_control_props u_props (.core_clk, .rst, .req, .wake_in, .clock_recovery_en,
   .recovery_trim, .osc_run, .osc_trim, .core_clock_tick, .sys_clock_source, .usb_clock_source, .suspended);
`default_nettype wire

/* File: sim/hf_osc_control_tb.sv */
// Self-checking bench for the oscillator control block
`default_nettype none
module hf_osc_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] FT = 5'h0b; // Arbitrary factory trim
   logic core_clk = 0, rst = 1, rec_en = 0, pol = 0, rd_q = 0, osc_run, tick, suspended;
   logic [1:0] mode = 0;
   logic [4:0] rec_trim = 0, v, osc_trim;
   logic [7:0] rdata;
   hf_osc_pkg::reg_req_s req = '0;
   hf_osc_pkg::wake_s wake_in;
   logic [7:0] exp_q[$];
   int fail_count = 0, num_checks = 0, cyc = 0, n;
   hf_osc_control #(.FACTORY_TRIM(FT)) u_dut (.core_clk, .rst, .req, .rdata, .wake_in, .clock_recovery_en(rec_en),
      .recovery_trim(rec_trim), .osc_run, .osc_trim, .core_clock_tick(tick), .sys_clock_source(),
      .usb_clock_source(), .suspended);
   wake_source_model u_wake (.core_clk, .mode, .pol, .wake_in);
   initial forever #5 core_clk = !core_clk;
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Register port accesses, one cycle each
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge core_clk) req <= '{1'b1, 1'b0, a, d};
      @(negedge core_clk) req <= '0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(negedge core_clk) req <= '{1'b0, 1'b1, a, 8'h00};
      exp_q.push_back(e);
      @(negedge core_clk) req <= '0;
   endtask
   // Count core clock ticks over a whole number of periods
   task automatic ticks(int div);
      n = 0;
      repeat (8) @(negedge core_clk);
      repeat (64) @(negedge core_clk) n += tick;
      check("ticks", 8'(n), 8'(64 / div));
   endtask
   // Compare read answers with the oldest note; timeout
   always @(posedge core_clk) begin
      if (rd_q) check("rdata", rdata, exp_q.pop_front());
      rd_q <= req.rd && !rst;
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      void'($urandom(96));
      repeat (2) @(negedge core_clk);
      rst = 0;
      rd(hf_osc_pkg::ADDR_CONTROL, 8'h80);
      rd(hf_osc_pkg::ADDR_TRIM, {3'h0, FT});
      rd(8'hb4, 8'h00);
      repeat (110) @(negedge core_clk);
      for (int i = 0; i < 4; i++) begin
         wr(hf_osc_pkg::ADDR_CONTROL, 8'h80 | 8'(i));
         rd(hf_osc_pkg::ADDR_CONTROL, 8'hc0 | 8'(i));
         ticks(8 >> i);
      end
      for (int k = 1; k < 3; k++) begin
         pol = 1'($urandom);
         wr(hf_osc_pkg::ADDR_CONTROL, 8'ha3);
         repeat (10) @(negedge core_clk);
         check("suspend", {6'h0, suspended, osc_run}, 8'h02);
         mode = 2'(k);
         repeat (4) @(negedge core_clk);
         check("wake", {6'h0, suspended, osc_run}, 8'h01);
         mode = 0;
         repeat (110) @(negedge core_clk);
         rd(hf_osc_pkg::ADDR_CONTROL, 8'hc3);
      end
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
         wr(hf_osc_pkg::ADDR_TRIM, {3'h0, v});
         rd(hf_osc_pkg::ADDR_TRIM, {3'h0, v});
      end
      rec_trim = 5'($urandom);
      rec_en = 1;
      wr(hf_osc_pkg::ADDR_TRIM, {3'h0, ~rec_trim});
      check("recovery trim", {3'h0, osc_trim}, {3'h0, rec_trim});
      rec_en = 0;
      wr(hf_osc_pkg::ADDR_CONTROL, 8'h00);
      @(negedge core_clk);
      check("stopped", {7'h0, osc_run}, 8'h00);
      rd(hf_osc_pkg::ADDR_CONTROL, 8'h00);
      wr(hf_osc_pkg::ADDR_CONTROL, 8'h81);
      repeat (110) @(negedge core_clk);
      rd(hf_osc_pkg::ADDR_CONTROL, 8'hc1);
      ticks(4);
      repeat (3) @(negedge core_clk);
      close_out();
   end
endmodule // hf_osc_control_tb
`default_nettype wire

/* File: sim/wake_source_model.sv */
// Wake source model: USB transceiver and bus-power detector
`default_nettype none
module wake_source_model (
   input wire logic core_clk,
   input wire logic [1:0] mode,
   input wire logic pol,
   output hf_osc_pkg::wake_s wake_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus and mismatched power unless told otherwise
   always @(negedge core_clk) begin
      wake_in.usb_event <= (mode == 2'h1);
      wake_in.bus_power_level <= (mode == 2'h2) ? pol : !pol;
      wake_in.bus_power_polarity_select <= pol;
   end
endmodule // wake_source_model
`default_nettype wire

/* File: verilog/core_clock_divider.sv */
// Module: enable-pulse divider for the core clock (by 1, 2, 4 or 8)
`default_nettype none
module core_clock_divider (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [1:0] divide_select,
   output logic tick
);
   logic [2:0] count_q;
   logic [2:0] count_d;
   logic [2:0] last;

   // Terminal count per divide code
   always_comb begin
      unique case (divide_select)
         hf_osc_pkg::DIV_BY_8: last = hf_osc_pkg::LAST_BY_8;
         hf_osc_pkg::DIV_BY_4: last = hf_osc_pkg::LAST_BY_4;
         hf_osc_pkg::DIV_BY_2: last = hf_osc_pkg::LAST_BY_2;
         hf_osc_pkg::DIV_BY_1: last = hf_osc_pkg::LAST_BY_1;
      endcase
      tick = run && (count_q >= last);
      if (!run || tick) begin
         count_d = hf_osc_pkg::DIV_COUNT_FIRST;
      end else begin
         count_d = count_q + hf_osc_pkg::DIV_COUNT_STEP;
      end
   end

   // Counter register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_q <= hf_osc_pkg::DIV_COUNT_FIRST;
      end else begin
         count_q <= count_d;
      end
   end
endmodule // core_clock_divider
`default_nettype wire

/* File: verilog/hf_osc_control.sv */
// Module: high-frequency oscillator control and core clock derivation
`default_nettype none
module hf_osc_control #(
   parameter logic [4:0] FACTORY_TRIM = 5'h10
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire hf_osc_pkg::reg_req_s req,
   output logic [7:0] rdata,
   input wire hf_osc_pkg::wake_s wake_in,
   input wire logic clock_recovery_en,
   input wire logic [4:0] recovery_trim,
   output logic osc_run,
   output logic [4:0] osc_trim,
   output logic core_clock_tick,
   output hf_osc_pkg::sys_src_e sys_clock_source,
   output hf_osc_pkg::usb_src_e usb_clock_source,
   output logic suspended
);
   // Sequencer state
   hf_osc_pkg::osc_state_e state_q;
   hf_osc_pkg::osc_state_e state_d;

   // Register fields
   logic enable_q;
   logic enable_d;
   logic [1:0] div_q;
   logic [1:0] div_d;
   logic [4:0] trim_q;
   logic [4:0] trim_d;

   // Settling counter
   logic [7:0] settle_q;
   logic [7:0] settle_d;
   logic settle_done;

   // Clock source selections
   hf_osc_pkg::sys_src_e sys_src_q;
   hf_osc_pkg::sys_src_e sys_src_d;
   hf_osc_pkg::usb_src_e usb_src_q;
   hf_osc_pkg::usb_src_e usb_src_d;

   // Read path
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [7:0] control_view;
   logic [7:0] trim_view;

   // Decoded requests and write fields
   logic ctl_wr;
   logic trim_wr;
   logic ctl_rd;
   logic trim_rd;
   logic wr_enable;
   logic wr_suspend;
   logic [1:0] wr_divide;
   logic [4:0] wr_trim;

   // Sequencer status
   logic wake;
   logic ready;
   logic settling;
   logic sleeping;
   logic stop_req;
   logic suspend_req;

   wake_detect u_wake (
      .core_clk(core_clk),
      .rst(rst),
      .wake_in(wake_in),
      .wake(wake)
   );

   core_clock_divider u_div (
      .core_clk(core_clk),
      .rst(rst),
      .run(ready),
      .divide_select(div_q),
      .tick(core_clock_tick)
   );

   // Address decode of the register port
   always_comb begin
      ctl_wr = req.wr && (req.addr == hf_osc_pkg::ADDR_CONTROL);
      trim_wr = req.wr && (req.addr == hf_osc_pkg::ADDR_TRIM);
      ctl_rd = req.rd && (req.addr == hf_osc_pkg::ADDR_CONTROL);
      trim_rd = req.rd && (req.addr == hf_osc_pkg::ADDR_TRIM);
   end

   // Fields carried by a write
   always_comb begin
      wr_enable = req.wdata[hf_osc_pkg::ENABLE_BIT];
      wr_suspend = req.wdata[hf_osc_pkg::SUSPEND_BIT];
      wr_divide = req.wdata[hf_osc_pkg::DIV_MSB:0];
      wr_trim = req.wdata[hf_osc_pkg::TRIM_MSB:0];
   end

   // Sequencer status from the state register, settling counter, enable bit and control writes
   always_comb begin
      ready = (state_q == hf_osc_pkg::OSC_RUN);
      settling = (state_q == hf_osc_pkg::OSC_SETTLE);
      sleeping = (state_q == hf_osc_pkg::OSC_SUSPEND);
      settle_done = (settle_q == hf_osc_pkg::SETTLE_LAST);
      stop_req = !enable_q;
      suspend_req = ctl_wr && wr_suspend;
   end

   // Enable bit, next value
   always_comb begin
      enable_d = enable_q;
      if (ctl_wr) begin
         enable_d = wr_enable;
      end
   end

   // Enable bit register, set at reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_q <= hf_osc_pkg::CONTROL_RESET[hf_osc_pkg::ENABLE_BIT];
      end else begin
         enable_q <= enable_d;
      end
   end

   // Divide select, next value
   always_comb begin
      div_d = div_q;
      if (ctl_wr) begin
         div_d = wr_divide;
      end
   end

   // Divide select register, divide by eight at reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_q <= hf_osc_pkg::DIV_RESET;
      end else begin
         div_q <= div_d;
      end
   end

   // Trim, next value; clock recovery overrides software writes
   always_comb begin
      trim_d = trim_q;
      if (clock_recovery_en) begin
         trim_d = recovery_trim;
      end else if (trim_wr) begin
         trim_d = wr_trim;
      end
   end

   // Trim register, factory value at reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         trim_q <= FACTORY_TRIM;
      end else begin
         trim_q <= trim_d;
      end
   end

   // Settling counter, counts only while settling
   always_comb begin
      settle_d = hf_osc_pkg::SETTLE_FIRST;
      if (settling) begin
         settle_d = settle_q + hf_osc_pkg::SETTLE_STEP;
      end
   end

   // Settling counter register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         settle_q <= hf_osc_pkg::SETTLE_FIRST;
      end else begin
         settle_q <= settle_d;
      end
   end

   // Oscillator state sequence; disable wins over every other request
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         hf_osc_pkg::OSC_OFF: begin
            if (enable_q) begin
               state_d = hf_osc_pkg::OSC_SETTLE;
            end
         end
         hf_osc_pkg::OSC_SETTLE: begin
            if (stop_req) begin
               state_d = hf_osc_pkg::OSC_OFF;
            end else if (settle_done) begin
               state_d = hf_osc_pkg::OSC_RUN;
            end
         end
         hf_osc_pkg::OSC_RUN: begin
            if (stop_req) begin
               state_d = hf_osc_pkg::OSC_OFF;
            end else if (suspend_req) begin
               state_d = hf_osc_pkg::OSC_SUSPEND;
            end
         end
         hf_osc_pkg::OSC_SUSPEND: begin
            if (stop_req) begin
               state_d = hf_osc_pkg::OSC_OFF;
            end else if (wake) begin
               state_d = hf_osc_pkg::OSC_SETTLE;
            end
         end
      endcase
   end

   // State register; oscillator starts up out of reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= hf_osc_pkg::OSC_SETTLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Core clock source, held; no selection logic in this block
   always_comb begin
      sys_src_d = sys_src_q;
   end

   // Core clock source register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sys_src_q <= hf_osc_pkg::SRC_HF_OSC;
      end else begin
         sys_src_q <= sys_src_d;
      end
   end

   // USB clock source, held
   always_comb begin
      usb_src_d = usb_src_q;
   end

   // USB clock source register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         usb_src_q <= hf_osc_pkg::USB_SRC_HF_OSC;
      end else begin
         usb_src_q <= usb_src_d;
      end
   end

   // Control register image; suspend bit reads zero
   always_comb begin
      control_view = hf_osc_pkg::READ_IDLE;
      control_view[hf_osc_pkg::ENABLE_BIT] = enable_q;
      control_view[hf_osc_pkg::READY_BIT] = ready;
      control_view[hf_osc_pkg::DIV_MSB:0] = div_q;
   end

   // Trim register image
   always_comb begin
      trim_view = hf_osc_pkg::READ_IDLE;
      trim_view[hf_osc_pkg::TRIM_MSB:0] = trim_q;
   end

   // Read data, next value; unmapped reads give zero
   always_comb begin
      rdata_d = hf_osc_pkg::READ_IDLE;
      if (ctl_rd) begin
         rdata_d = control_view;
      end else if (trim_rd) begin
         rdata_d = trim_view;
      end
   end

   // Read data register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= hf_osc_pkg::READ_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Outputs
   always_comb begin
      rdata = rdata_q;
      osc_run = settling || ready;
      osc_trim = trim_q;
      suspended = sleeping;
      sys_clock_source = sys_src_q;
      usb_clock_source = usb_src_q;
   end
endmodule // hf_osc_control
`default_nettype wire

/* File: verilog/hf_osc_pkg.sv */
// Package: register map, field layout and timing constants of the oscillator control
`default_nettype none
package hf_osc_pkg;
   // Register addresses on the register port
   localparam logic [7:0] ADDR_CONTROL = 8'hb2;
   localparam logic [7:0] ADDR_TRIM = 8'hb3;
   // Control register fields
   localparam int ENABLE_BIT = 7;
   localparam int READY_BIT = 6;
   localparam int SUSPEND_BIT = 5;
   localparam logic [7:0] CONTROL_RESET = 8'h80;
   localparam int DIV_MSB = 1;
   localparam logic [7:0] READ_IDLE = 8'h00;
   // Divide select codes
   localparam logic [1:0] DIV_BY_8 = 2'h0;
   localparam logic [1:0] DIV_BY_4 = 2'h1;
   localparam logic [1:0] DIV_BY_2 = 2'h2;
   localparam logic [1:0] DIV_BY_1 = 2'h3;
   localparam logic [1:0] DIV_RESET = DIV_BY_8;
   // Divider counts, terminal count is one less than the ratio
   localparam logic [2:0] DIV_COUNT_FIRST = 3'h0;
   localparam logic [2:0] DIV_COUNT_STEP = 3'h1;
   localparam logic [2:0] LAST_BY_8 = 3'h7;
   localparam logic [2:0] LAST_BY_4 = 3'h3;
   localparam logic [2:0] LAST_BY_2 = 3'h1;
   localparam logic [2:0] LAST_BY_1 = 3'h0;
   // Trim field
   localparam int TRIM_W = 5;
   localparam int TRIM_MSB = TRIM_W - 1;
   localparam logic [4:0] TRIM_FASTEST = 5'h00;
   localparam logic [4:0] TRIM_SLOWEST = 5'h1f;
   // Oscillator settling time
   localparam int SETTLE_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = 8;
   localparam logic [SETTLE_W-1:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
   localparam logic [SETTLE_W-1:0] SETTLE_FIRST = 8'h00;
   localparam logic [SETTLE_W-1:0] SETTLE_STEP = 8'h01;
   // Clock source selections
   typedef enum logic [1:0] {
      SRC_HF_OSC = 2'h0,
      SRC_LF_OSC = 2'h1,
      SRC_EXT_OSC = 2'h2,
      SRC_MULT = 2'h3
   } sys_src_e;
   typedef enum logic [1:0] {
      USB_SRC_HF_OSC = 2'h0,
      USB_SRC_EXT_OSC = 2'h1,
      USB_SRC_MULT = 2'h2
   } usb_src_e;
   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
   // Wake sources from transceiver and bus-power detector
   typedef struct packed {
      logic usb_event;
      logic bus_power_level;
      logic bus_power_polarity_select;
   } wake_s;
   // Oscillator states
   typedef enum logic [1:0] {
      OSC_OFF = 2'b00,
      OSC_SETTLE = 2'b01,
      OSC_RUN = 2'b11,
      OSC_SUSPEND = 2'b10
   } osc_state_e;
endpackage
`default_nettype wire

/* File: verilog/wake_detect.sv */
// Module: wake request from USB activity or bus-power polarity match
`default_nettype none
module wake_detect (
   input wire logic core_clk,
   input wire logic rst,
   input wire hf_osc_pkg::wake_s wake_in,
   output logic wake
);
   logic usb_q;
   logic match_q;
   logic usb_d;
   logic match_d;

   // Transceiver sense runs even when it is disabled
   always_comb begin
      usb_d = wake_in.usb_event;
      match_d = (wake_in.bus_power_level == wake_in.bus_power_polarity_select);
      wake = usb_q || match_q;
   end

   // Registered wake sources
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         usb_q <= 1'b0;
         match_q <= 1'b0;
      end else begin
         usb_q <= usb_d;
         match_q <= match_d;
      end
   end
endmodule // wake_detect
`default_nettype wire
